// [inc/mem_map_cfg.svh]
// Constants for the memory block mapper and its controller.
`ifndef MEM_MAP_CFG_SVH
`define MEM_MAP_CFG_SVH

// ****************
// Device register addresses and reset values
// ****************
`define SPLIT_START_REG 8'hE0
`define MEM_ENCODING_REG 8'hE1
`define ENC_RESET 8'hFF
`define SPLIT_RESET 8'h00

// ****************
// Encoding register fields
// ****************
`define F_CONN2 7:6
`define F_CONN1 5:4
`define F_SPLIT_DIS_N 3
`define F_SPLIT_AT_512 2
`define F_ROM_ACTIVE 1
`define F_PAR_DIS_N 0
`define F_SPLIT_A 3:0
`define CARD_ON 2'h2

// ****************
// Address map
// ****************
`define A_MB 31:20
`define A_START 23:20
`define A_HIGH 31:24
`define A_OFS 19:0
`define A_ROM 19:17
`define A_ROM_OFS 16:0
`define FIRST_MB 12'h000
`define EXT_MB 12'h001
`define ROM_PAGE 3'h7
`define LOW_640_END 20'hA0000
`define LOW_512_END 20'h80000
`define SIZE_384K 20'h60000
`define SIZE_512K 20'h80000

// ****************
// Controller APB registers and fields
// ****************
`define CTRL_OFS 12'h000
`define MADDR_OFS 12'h004
`define MDATA_OFS 12'h008
`define STATUS_OFS 12'h00C
`define C_GO 0
`define C_MEM 1
`define C_WRITE 2
`define C_RDATA 15:8
`define C_RADDR 23:16
`define S_BUSY 0
`define S_CLAIM 1
`define S_TARGET 4:2
`define S_RDATA 15:8
`define S_PERR 16

`endif

// [inc/mem_map_pkg.sv]
// Types shared by the memory block mapper and its controller.
package mem_map_pkg;

    typedef enum logic [2:0] {
        TGT_NONE,
        TGT_LOW,
        TGT_ROM,
        TGT_ROM_RAM,
        TGT_SPLIT,
        TGT_EXT
    } target_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WAIT
    } host_phase_t;

endpackage

// [inc/mem_map_if.sv]
// Link between the memory block mapper and the party that drives it.
`timescale 1ns/10ps
interface mem_map_if;
    logic reg_req;
    logic reg_write;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_ack;
    logic [7:0] reg_rdata;
    logic mem_req;
    logic mem_write;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic mem_ack;
    logic mem_claim;
    mem_map_pkg::target_t mem_target;
    logic parity_error;

    modport device (
        input reg_req, reg_write, reg_addr, reg_wdata, mem_req, mem_write, mem_addr, mem_wdata,
        output reg_ack, reg_rdata, mem_ack, mem_claim, mem_target, parity_error
    );

    modport host (
        output reg_req, reg_write, reg_addr, reg_wdata, mem_req, mem_write, mem_addr, mem_wdata,
        input reg_ack, reg_rdata, mem_ack, mem_claim, mem_target, parity_error
    );
endinterface

// [design/mem_block_mapper.sv]
// Memory block mapper: configuration registers, address decode and byte parity.
//
// How it works
// - Memory enabled in whole 1MB aligned blocks.
// - Connector 2 code 10 on, 11 off.
// - Connector 1 code 10 on, 11 off.
// - Split block decoded only when enabled.
// - Split block 384KB or 512KB by split point.
// - Split 640: low 640KB at address zero.
// - Split 512: low 512KB; 80000-9FFFF unclaimed.
// - ROM off: E0000-FFFFF goes to RAM.
// - Software avoids ROM off with split on.
// - Split and ROM off: 128KB at ROM.
// - Split on, ROM on: whole high part moved.
// - ROM replaced: 256KB or 384KB unused.
// - Parity bit low checks; toggle clears error.
// - Start bits give address bits 23-20.
// - Software avoids zero start with split on.
// - Software writes zero to reserved start bits.
// - No split block at 16MB total memory.
// - Split start register reads back written value.
// - One parity bit per byte, 36-bit memory.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "mem_map_cfg.svh"
module mem_block_mapper (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Link to the processor side.
    mem_map_if.device bus,
    // Memory array side.
    output logic ram_select,
    output logic ram_card,
    output logic [19:0] ram_offset,
    output logic ram_write,
    output logic [31:0] wr_data,
    output logic [3:0] wr_parity,
    output logic rom_select,
    input wire logic [31:0] rd_data,
    input wire logic [3:0] rd_parity
);

    // ****************
    // State
    // ****************
    typedef struct packed {
        logic [7:0] split_start;
        logic [7:0] encoding;
        logic reg_ack;
        logic [7:0] reg_rdata;
        logic mem_ack;
        logic claimed;
        mem_map_pkg::target_t target;
        logic ram_select;
        logic ram_card;
        logic [19:0] ram_offset;
        logic ram_write;
        logic [31:0] wr_data;
        logic [3:0] wr_parity;
        logic rom_select;
        logic check_pending;
        logic parity_error;
    } dev_state_t;

    dev_state_t s;
    dev_state_t next_s;

    // ****************
    // Byte parity
    // ****************
    logic [3:0] gen_parity;
    logic [3:0] byte_bad;

    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_byte
            // Odd parity: the byte and its bit hold an odd count of ones.
            assign gen_parity[i] = ~^bus.mem_wdata[8*i +: 8];
            assign byte_bad[i] = ~^{rd_parity[i], rd_data[8*i +: 8]};
        end
    endgenerate

    // ****************
    // Address decode and register access
    // ****************
    logic conn1_on;
    logic conn2_on;
    logic any_on;
    logic both_on;
    logic split_on;
    logic [19:0] low_end;
    logic [19:0] split_size;
    logic [19:0] ofs;
    logic in_first_mb;
    logic in_split;
    logic par_clear;
    logic par_set;
    mem_map_pkg::target_t tgt;
    logic tgt_card;
    logic [19:0] tgt_ofs;

    always_comb
    begin
        conn1_on = s.encoding[`F_CONN1] == `CARD_ON;
        conn2_on = s.encoding[`F_CONN2] == `CARD_ON;
        any_on = conn1_on | conn2_on;
        both_on = conn1_on & conn2_on;
        split_on = ~s.encoding[`F_SPLIT_DIS_N];
        low_end = s.encoding[`F_SPLIT_AT_512] ? `LOW_512_END : `LOW_640_END;
        split_size = s.encoding[`F_SPLIT_AT_512] ? `SIZE_512K : `SIZE_384K;
        ofs = bus.mem_addr[`A_OFS];
        in_first_mb = bus.mem_addr[`A_MB] == `FIRST_MB;
        // The split block sits on the 1MB boundary named by the start bits.
        in_split = split_on && (bus.mem_addr[`A_HIGH] == 8'h00)
            && (bus.mem_addr[`A_START] == s.split_start[`F_SPLIT_A])
            && (ofs < split_size);

        tgt = mem_map_pkg::TGT_NONE;
        // The first active block is connector 1 when present, else connector 2.
        tgt_card = ~conn1_on;
        tgt_ofs = ofs;
        if (any_on && in_first_mb && (ofs < low_end))
        begin
            tgt = mem_map_pkg::TGT_LOW;
        end
        else if (in_first_mb && (bus.mem_addr[`A_ROM] == `ROM_PAGE))
        begin
            if (s.encoding[`F_ROM_ACTIVE])
            begin
                tgt = mem_map_pkg::TGT_ROM;
            end
            else if (any_on)
            begin
                // The 128KB just above the low region stands in for the ROM.
                tgt = mem_map_pkg::TGT_ROM_RAM;
                tgt_ofs = low_end + {3'h0, ofs[`A_ROM_OFS]};
            end
        end
        else if (any_on && in_split)
        begin
            tgt = mem_map_pkg::TGT_SPLIT;
            tgt_ofs = low_end + ofs;
        end
        else if (both_on && (bus.mem_addr[`A_MB] == `EXT_MB))
        begin
            // The second active card follows as one whole 1MB block.
            tgt = mem_map_pkg::TGT_EXT;
            tgt_card = 1'b1;
        end
        // Holes in the first megabyte and all else stay unclaimed.

        next_s = s;
        next_s.reg_ack = 1'b0;
        next_s.mem_ack = 1'b0;
        next_s.ram_select = 1'b0;
        next_s.rom_select = 1'b0;
        next_s.ram_write = 1'b0;
        next_s.check_pending = 1'b0;

        par_clear = 1'b0;
        if (bus.reg_req)
        begin
            next_s.reg_ack = 1'b1;
            next_s.reg_rdata = 8'h00;
            if (bus.reg_addr == `SPLIT_START_REG)
            begin
                next_s.reg_rdata = s.split_start;
                if (bus.reg_write)
                begin
                    next_s.split_start = bus.reg_wdata;
                end
            end
            else if (bus.reg_addr == `MEM_ENCODING_REG)
            begin
                next_s.reg_rdata = s.encoding;
                if (bus.reg_write)
                begin
                    next_s.encoding = bus.reg_wdata;
                    par_clear = bus.reg_wdata[`F_PAR_DIS_N];
                end
            end
        end

        if (bus.mem_req)
        begin
            next_s.mem_ack = 1'b1;
            next_s.claimed = tgt != mem_map_pkg::TGT_NONE;
            next_s.target = tgt;
            next_s.ram_select = (tgt != mem_map_pkg::TGT_NONE) && (tgt != mem_map_pkg::TGT_ROM);
            next_s.rom_select = tgt == mem_map_pkg::TGT_ROM;
            next_s.ram_card = tgt_card;
            next_s.ram_offset = tgt_ofs;
            next_s.ram_write = bus.mem_write && next_s.ram_select;
            next_s.wr_data = bus.mem_wdata;
            next_s.wr_parity = gen_parity;
            // ROM carries no parity, so only RAM reads are checked.
            next_s.check_pending = ~bus.mem_write && next_s.ram_select;
        end

        // A check in the clearing cycle still latches the error.
        par_set = s.check_pending && ~s.encoding[`F_PAR_DIS_N] && (|byte_bad);
        next_s.parity_error = par_set | (s.parity_error & ~par_clear);
    end

    // ****************
    // Registers and outputs
    // ****************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.split_start <= `SPLIT_RESET;
            s.encoding <= `ENC_RESET;
            s.target <= mem_map_pkg::TGT_NONE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign bus.reg_ack = s.reg_ack;
    assign bus.reg_rdata = s.reg_rdata;
    assign bus.mem_ack = s.mem_ack;
    assign bus.mem_claim = s.claimed;
    assign bus.mem_target = s.target;
    assign bus.parity_error = s.parity_error;
    assign ram_select = s.ram_select;
    assign ram_card = s.ram_card;
    assign ram_offset = s.ram_offset;
    assign ram_write = s.ram_write;
    assign wr_data = s.wr_data;
    assign wr_parity = s.wr_parity;
    assign rom_select = s.rom_select;

endmodule

// [design/mem_map_host.sv]
// Controller that software drives over APB to program and exercise the mapper.
`timescale 1ns/10ps
`include "mem_map_cfg.svh"
module mem_map_host (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the mapper.
    mem_map_if.host bus
);

    // ****************
    // State
    // ****************
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        mem_map_pkg::host_phase_t phase;
        logic cmd_mem;
        logic cmd_write;
        logic [7:0] reg_addr;
        logic [7:0] reg_wdata;
        logic [31:0] maddr;
        logic [31:0] mdata;
        logic reg_req;
        logic mem_req;
        logic claimed;
        mem_map_pkg::target_t target;
        logic [7:0] reg_rdata;
    } host_state_t;

    host_state_t s;
    host_state_t next_s;
    logic access;
    logic mapped;
    logic [31:0] status;

    // ****************
    // APB decode and command sequencing
    // ****************
    always_comb
    begin
        next_s = s;
        next_s.reg_req = 1'b0;
        next_s.mem_req = 1'b0;
        access = psel && penable;
        mapped = (paddr == `CTRL_OFS) || (paddr == `MADDR_OFS)
            || (paddr == `MDATA_OFS) || (paddr == `STATUS_OFS);
        status = 32'h0000_0000;
        status[`S_BUSY] = s.phase != mem_map_pkg::PH_IDLE;
        status[`S_CLAIM] = s.claimed;
        status[`S_TARGET] = s.target;
        status[`S_RDATA] = s.reg_rdata;
        status[`S_PERR] = bus.parity_error;

        // One wait state lets the read data come from a flip-flop.
        next_s.pready = access && ~s.pready;
        if (access && ~s.pready)
        begin
            next_s.pslverr = ~mapped;
            next_s.prdata = 32'h0000_0000;
            if (~pwrite)
            begin
                if (paddr == `CTRL_OFS)
                begin
                    next_s.prdata = {8'h00, s.reg_addr, s.reg_wdata, 5'h00,
                        s.cmd_write, s.cmd_mem, 1'b0};
                end
                else if (paddr == `MADDR_OFS)
                begin
                    next_s.prdata = s.maddr;
                end
                else if (paddr == `MDATA_OFS)
                begin
                    next_s.prdata = s.mdata;
                end
                else if (paddr == `STATUS_OFS)
                begin
                    next_s.prdata = status;
                end
            end
        end

        // A write takes effect at the edge that completes the access.
        if (access && s.pready && pwrite)
        begin
            if (paddr == `MADDR_OFS)
            begin
                next_s.maddr = pwdata;
            end
            else if (paddr == `MDATA_OFS)
            begin
                next_s.mdata = pwdata;
            end
            else if ((paddr == `CTRL_OFS) && (s.phase == mem_map_pkg::PH_IDLE))
            begin
                // Register values are the software's to keep legal.
                next_s.cmd_mem = pwdata[`C_MEM];
                next_s.cmd_write = pwdata[`C_WRITE];
                next_s.reg_wdata = pwdata[`C_RDATA];
                next_s.reg_addr = pwdata[`C_RADDR];
                if (pwdata[`C_GO])
                begin
                    next_s.reg_req = ~pwdata[`C_MEM];
                    next_s.mem_req = pwdata[`C_MEM];
                    next_s.phase = mem_map_pkg::PH_WAIT;
                end
            end
        end

        unique case (s.phase)
            mem_map_pkg::PH_IDLE:
            begin
            end
            mem_map_pkg::PH_WAIT:
            begin
                if (bus.reg_ack)
                begin
                    next_s.reg_rdata = bus.reg_rdata;
                    next_s.phase = mem_map_pkg::PH_IDLE;
                end
                else if (bus.mem_ack)
                begin
                    next_s.claimed = bus.mem_claim;
                    next_s.target = bus.mem_target;
                    next_s.phase = mem_map_pkg::PH_IDLE;
                end
            end
            default:
            begin
                next_s.phase = mem_map_pkg::PH_IDLE;
            end
        endcase
    end

    // ****************
    // Registers and outputs
    // ****************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.phase <= mem_map_pkg::PH_IDLE;
            s.target <= mem_map_pkg::TGT_NONE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign bus.reg_req = s.reg_req;
    assign bus.reg_write = s.cmd_write;
    assign bus.reg_addr = s.reg_addr;
    assign bus.reg_wdata = s.reg_wdata;
    assign bus.mem_req = s.mem_req;
    assign bus.mem_write = s.cmd_write;
    assign bus.mem_addr = s.maddr;
    assign bus.mem_wdata = s.mdata;

endmodule

// [dv/mem_map_checker.sv]
// Concurrent checks on the link between the mapper and its controller.
`timescale 1ns/10ps
`include "mem_map_cfg.svh"
module mem_map_checker (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Link signals.
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_claim,
    input wire mem_map_pkg::target_t mem_target,
    input wire logic parity_error
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ****************
    // Shadow of the device configuration
    // ****************
    logic [7:0] enc;
    logic [3:0] spl;
    logic card_on;
    logic rom_rng;
    logic in_split;
    logic [19:0] low_end;
    logic [19:0] sz;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enc <= `ENC_RESET;
            spl <= 4'h0;
        end
        else if (reg_req && reg_write && reg_addr == `MEM_ENCODING_REG)
            enc <= reg_wdata;
        else if (reg_req && reg_write && reg_addr == `SPLIT_START_REG)
            spl <= reg_wdata[3:0];
    end

    assign card_on = enc[7:6] == `CARD_ON || enc[5:4] == `CARD_ON;
    assign rom_rng = mem_addr[31:17] == 15'h0007;
    assign low_end = enc[2] ? `LOW_512_END : `LOW_640_END;
    assign sz = enc[2] ? `SIZE_512K : `SIZE_384K;
    assign in_split = !enc[3] && mem_addr[31:24] == 8'h00 && mem_addr[23:20] == spl && spl != 4'h0;

    // ****************
    // Properties
    // ****************
    property p_reg_ack;
        reg_req |=> reg_ack;
    endproperty
    property p_mem_ack;
        mem_req |=> mem_ack ##1 !mem_ack;
    endproperty
    property p_low;
        mem_req && card_on && mem_addr < {12'h000, low_end} |=>
            mem_claim && mem_target == mem_map_pkg::TGT_LOW;
    endproperty
    property p_gap;
        mem_req && enc[2] && mem_addr[31:17] == 15'h0004 |=> !mem_claim;
    endproperty
    property p_rom;
        mem_req && rom_rng && enc[1] |=> mem_target == mem_map_pkg::TGT_ROM;
    endproperty
    property p_rom_ram;
        mem_req && rom_rng && !enc[1] && card_on |=> mem_target == mem_map_pkg::TGT_ROM_RAM;
    endproperty
    property p_split_off;
        mem_req && enc[3] |=> mem_target != mem_map_pkg::TGT_SPLIT;
    endproperty
    property p_split_in;
        mem_req && card_on && in_split && mem_addr[19:0] < sz |=>
            mem_target == mem_map_pkg::TGT_SPLIT;
    endproperty
    property p_split_out;
        mem_req && in_split && mem_addr[19:0] >= sz |=> mem_target != mem_map_pkg::TGT_SPLIT;
    endproperty
    property p_above;
        mem_req && mem_addr[31:24] != 8'h00 |=> !mem_claim;
    endproperty
    property p_no_card;
        mem_req && !card_on && !rom_rng |=> !mem_claim;
    endproperty
    property p_perr_hold;
        parity_error && !reg_req && !$past(reg_req) |=> parity_error;
    endproperty

    a_reg_ack: assert property (p_reg_ack) else $error("register access not answered");
    a_mem_ack: assert property (p_mem_ack) else $error("memory cycle not answered");
    a_low: assert property (p_low) else $error("low region not decoded");
    a_gap: assert property (p_gap) else $error("gap above 512KB claimed");
    a_rom: assert property (p_rom) else $error("active ROM not selected");
    a_rom_ram: assert property (p_rom_ram) else $error("ROM range not in RAM");
    a_split_off: assert property (p_split_off) else $error("disabled split decoded");
    a_split_in: assert property (p_split_in) else $error("split block missed");
    a_split_out: assert property (p_split_out) else $error("split block too large");
    a_above: assert property (p_above) else $error("address above 16MB claimed");
    a_no_card: assert property (p_no_card) else $error("claim without a card");
    a_perr_hold: assert property (p_perr_hold) else $error("parity error lost");

    c_split: cover property (mem_ack && mem_target == mem_map_pkg::TGT_SPLIT);
    c_rom_ram: cover property (mem_ack && mem_target == mem_map_pkg::TGT_ROM_RAM);
    c_perr: cover property ($rose(parity_error));
endmodule

// [dv/tb_system_memory_block_mapper.sv]
// Self-checking bench for the memory block mapper and its controller.
`timescale 1ns/10ps
`include "mem_map_cfg.svh"
module tb_system_memory_block_mapper;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ram_select;
    logic ram_card;
    logic [19:0] ram_offset;
    logic ram_write;
    logic [31:0] wr_data;
    logic [3:0] wr_parity;
    logic rom_select;
    logic [31:0] rd_data = 32'h00000000;
    logic [3:0] rd_parity = 4'hF;
    logic [19:0] seen_ofs;
    logic seen_card;
    logic [3:0] seen_par;
    logic [1:0] seen_sel;
    logic [31:0] seen_data;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int cmp_count = 0;

    mem_map_if bus ();
    always #20 pclk = ~pclk;

    mem_map_host u_mem_map_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus));
    mem_block_mapper u_mem_block_mapper (.pclk(pclk), .presetn(presetn), .bus(bus),
        .ram_select(ram_select), .ram_card(ram_card), .ram_offset(ram_offset),
        .ram_write(ram_write), .wr_data(wr_data), .wr_parity(wr_parity),
        .rom_select(rom_select), .rd_data(rd_data), .rd_parity(rd_parity));
    mem_map_checker u_mem_map_checker (.pclk(pclk), .presetn(presetn), .reg_req(bus.reg_req),
        .reg_write(bus.reg_write), .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata),
        .reg_ack(bus.reg_ack), .mem_req(bus.mem_req), .mem_addr(bus.mem_addr),
        .mem_ack(bus.mem_ack), .mem_claim(bus.mem_claim), .mem_target(bus.mem_target),
        .parity_error(bus.parity_error));

    // Keeps what the memory array side saw on the last claimed cycle.
    always @(posedge pclk)
    begin
        if (ram_select === 1'b1 || rom_select === 1'b1)
        begin
            seen_ofs <= ram_offset;
            seen_card <= ram_card;
            seen_par <= wr_parity;
            seen_sel <= {rom_select, ram_write};
            seen_data <= wr_data;
        end
    end

    // ****************
    // Common tasks
    // ****************
    task automatic results();
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic chk_tgt(input mem_map_pkg::target_t exp, input mem_map_pkg::target_t got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD target exp %0d got %0d", exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 20)
        begin
            @(posedge pclk);
            i++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 20)
        begin
            n_fail++;
            results();
        end
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 20; i++)
        begin
            apb(1'b0, `STATUS_OFS, 32'h0);
            if (rd[`S_BUSY] === 1'b0)
                return;
        end
        n_fail++;
        results();
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, `CTRL_OFS, {8'h00, a, d, 8'h05});
        wait_idle();
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b1, `CTRL_OFS, {8'h00, a, 8'h00, 8'h01});
        wait_idle();
        chk("reg_rdata", {24'h0, exp}, {24'h0, rd[`S_RDATA]});
    endtask

    task automatic mem(input logic wr, input logic [31:0] a, input logic [31:0] d,
        input mem_map_pkg::target_t exp);
        apb(1'b1, `MADDR_OFS, a);
        apb(1'b1, `MDATA_OFS, d);
        apb(1'b1, `CTRL_OFS, {29'h0, wr, 2'h3});
        wait_idle();
        chk_tgt(exp, mem_map_pkg::target_t'(rd[`S_TARGET]));
        chk("claim", {31'h0, exp != mem_map_pkg::TGT_NONE}, {31'h0, rd[`S_CLAIM]});
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        reg_rd(`MEM_ENCODING_REG, `ENC_RESET);
        reg_rd(`SPLIT_START_REG, `SPLIT_RESET);
        mem(1'b0, 32'h00000000, 32'h0, mem_map_pkg::TGT_NONE);
        mem(1'b0, 32'h000E0000, 32'h0, mem_map_pkg::TGT_ROM);
        apb(1'b0, 12'h010, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
    endtask

    task automatic t_split640();
        reg_wr(`SPLIT_START_REG, 8'h0F);
        reg_rd(`SPLIT_START_REG, 8'h0F);
        reg_wr(`MEM_ENCODING_REG, 8'hA2);
        mem(1'b0, 32'h0009FFFF, 32'h0, mem_map_pkg::TGT_LOW);
        mem(1'b0, 32'h000A0000, 32'h0, mem_map_pkg::TGT_NONE);
        mem(1'b0, 32'h000E0000, 32'h0, mem_map_pkg::TGT_ROM);
        chk("rom_select", 32'h2, {30'h0, seen_sel});
        mem(1'b0, 32'h00F00010, 32'h0, mem_map_pkg::TGT_SPLIT);
        chk("split offset", 32'h000A0010, {12'h0, seen_ofs});
        mem(1'b0, 32'h00F5FFFF, 32'h0, mem_map_pkg::TGT_SPLIT);
        mem(1'b0, 32'h00F60000, 32'h0, mem_map_pkg::TGT_NONE);
        mem(1'b0, 32'h00100000, 32'h0, mem_map_pkg::TGT_EXT);
        chk("ext card", 32'h1, {31'h0, seen_card});
        mem(1'b0, 32'h00200000, 32'h0, mem_map_pkg::TGT_NONE);
        mem(1'b1, 32'h00000010, 32'h01030700, mem_map_pkg::TGT_LOW);
        chk("wr_parity", 32'h5, {28'h0, seen_par});
        chk("ram_write", 32'h1, {30'h0, seen_sel});
        chk("wr_data", 32'h01030700, seen_data);
    endtask

    task automatic t_split512();
        reg_wr(`MEM_ENCODING_REG, 8'hA6);
        mem(1'b0, 32'h0007FFFF, 32'h0, mem_map_pkg::TGT_LOW);
        mem(1'b0, 32'h00080000, 32'h0, mem_map_pkg::TGT_NONE);
        mem(1'b0, 32'h00F7FFFF, 32'h0, mem_map_pkg::TGT_SPLIT);
        mem(1'b0, 32'h00F80000, 32'h0, mem_map_pkg::TGT_NONE);
    endtask

    task automatic t_rom_ram();
        reg_wr(`MEM_ENCODING_REG, 8'hA8);
        mem(1'b0, 32'h000E0000, 32'h0, mem_map_pkg::TGT_ROM_RAM);
        chk("rom ram offset", 32'h000A0000, {12'h0, seen_ofs});
        mem(1'b0, 32'h000FFFFF, 32'h0, mem_map_pkg::TGT_ROM_RAM);
        mem(1'b0, 32'h00F00000, 32'h0, mem_map_pkg::TGT_NONE);
    endtask

    task automatic t_cards();
        reg_wr(`MEM_ENCODING_REG, 8'hB2);
        mem(1'b0, 32'h00000000, 32'h0, mem_map_pkg::TGT_LOW);
        chk("card conn2", 32'h1, {31'h0, seen_card});
        reg_wr(`MEM_ENCODING_REG, 8'hE2);
        mem(1'b0, 32'h00000000, 32'h0, mem_map_pkg::TGT_LOW);
        chk("card conn1", 32'h0, {31'h0, seen_card});
        mem(1'b0, 32'h00100000, 32'h0, mem_map_pkg::TGT_NONE);
    endtask

    task automatic t_parity();
        reg_wr(`MEM_ENCODING_REG, 8'hA3);
        // Only the top byte carries a wrong parity bit.
        rd_data <= 32'h01030700;
        rd_parity <= 4'hD;
        mem(1'b0, 32'h00000000, 32'h0, mem_map_pkg::TGT_LOW);
        chk("perr off", 32'h0, {31'h0, bus.parity_error});
        reg_wr(`MEM_ENCODING_REG, 8'hA2);
        mem(1'b0, 32'h00000000, 32'h0, mem_map_pkg::TGT_LOW);
        chk("perr set", 32'h1, {31'h0, bus.parity_error});
        reg_wr(`MEM_ENCODING_REG, 8'hA3);
        reg_wr(`MEM_ENCODING_REG, 8'hA2);
        chk("perr clear", 32'h0, {31'h0, bus.parity_error});
        rd_parity <= 4'h5;
        mem(1'b0, 32'h00000000, 32'h0, mem_map_pkg::TGT_LOW);
        chk("perr good", 32'h0, {31'h0, bus.parity_error});
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_split640();
        t_split512();
        t_rom_ram();
        t_cards();
        t_parity();
        results();
    end
endmodule
